// *** design/pei_pkg.sv ***
package pei_pkg;

	// management register addresses
	localparam logic [4:0] REG_STATUS1 = 5'h01;
	localparam logic [4:0] REG_AN_EXP = 5'h06;
	localparam logic [4:0] REG_MODE_CS = 5'h11;
	localparam logic [4:0] REG_SRC_FLAGS = 5'h1d;
	localparam logic [4:0] REG_IRQ_MASK = 5'h1e;

	// source bit positions in flag and mask registers
	localparam int SRC_LO = 1;
	localparam int SRC_HI = 7;
	localparam int SRC_ENERGY = 7;

	// bits of the mode control/status register handled here
	localparam int MODE_CS_ENERGY_BIT = 1;
	localparam int MODE_CS_ALT_BIT = 6;

	// per-source clear behaviour in the primary scheme
	localparam logic [7:0] FALL_CLR_SET = 8'hee;
	localparam logic [7:0] RD_STATUS1_CLR_SET = 8'h30;
	localparam logic [7:0] RD_AN_EXP_CLR_SET = 8'h06;
	localparam logic [7:0] RESTART_CLR_SET = 8'h06;

	// values after reset
	localparam logic [15:0] IRQ_MASK_RST = 16'h0080;
	localparam logic ALT_SEL_RST = 1'b0;

	// management frame
	localparam int SMI_PRE_LEN = 32;
	localparam int SMI_HDR_LAST = 12;
	localparam int SMI_DATA_LAST = 15;
	localparam logic [1:0] SMI_OP_RD = 2'h2;
	localparam logic [1:0] SMI_OP_WR = 2'h1;

	// timing
	localparam int unsigned CLK_KHZ = 250000;
	localparam int unsigned ED_DELAY_MS = 1000;
	localparam int unsigned ED_PULSE_MS = 256;
	localparam int unsigned ED_DELAY_CYC = ED_DELAY_MS * CLK_KHZ;
	localparam int unsigned ED_PULSE_CYC = ED_PULSE_MS * CLK_KHZ;

	typedef enum logic [3:0]
	{
		SMI_PRE = 4'h1,
		SMI_HDR = 4'h2,
		SMI_TA = 4'h4,
		SMI_DATA = 4'h8
	} pei_smi_state_t;

	typedef enum logic [2:0]
	{
		ED_IDLE = 3'h1,
		ED_WAIT = 3'h2,
		ED_PULSE = 3'h4
	} pei_ed_state_t;

endpackage

// *** design/pei_smi_slave.sv ***
`timescale 1ns/1ns
module pei_smi_slave
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	// own address
	input wire logic [4:0] phy_addr,
	// register access
	input wire logic [15:0] rd_data,
	output logic rd_req,
	output logic wr_req,
	output logic [4:0] reg_addr,
	output logic [15:0] wr_data
);

	logic mdc_s1_r;
	logic mdc_s2_r;
	logic mdc_s3_r;
	logic mdio_s1_r;
	logic mdio_s2_r;
	logic mdc_rise;
	logic [12:0] hdr;
	pei_pkg::pei_smi_state_t state_r;
	logic [5:0] ones_r;
	logic [4:0] cnt_r;
	logic [15:0] shift_r;
	logic is_rd_r;

	////////////////////////////////////////////////////////////////////////
	// pins come from the host's domain
	always_ff @(posedge mclk)
	begin
		mdc_s1_r <= mdc;
		mdc_s2_r <= mdc_s1_r;
		mdc_s3_r <= mdc_s2_r;
		mdio_s1_r <= mdio_in;
		mdio_s2_r <= mdio_s1_r;
	end

	// data is taken on the rising management clock
	assign mdc_rise = mdc_s2_r & ~mdc_s3_r; // [R16]
	assign hdr = {shift_r[11:0], mdio_s2_r};

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_r <= pei_pkg::SMI_PRE;
			ones_r <= 6'h00;
			cnt_r <= 5'h00;
			shift_r <= 16'h0000;
			is_rd_r <= 1'b0;
			rd_req <= 1'b0;
			wr_req <= 1'b0;
			reg_addr <= 5'h00;
			wr_data <= 16'h0000;
			mdio_out <= 1'b0;
			mdio_oe_n <= 1'b1;
		end
		else
		begin
			rd_req <= 1'b0;
			wr_req <= 1'b0;
			if (mdc_rise)
			begin
				case (state_r)
					pei_pkg::SMI_PRE:
					begin
						cnt_r <= 5'h00;
						if (mdio_s2_r)
						begin
							if (ones_r != 6'(pei_pkg::SMI_PRE_LEN))
								ones_r <= ones_r + 6'h01;
						end
						else
						begin
							ones_r <= 6'h00;
							if (ones_r == 6'(pei_pkg::SMI_PRE_LEN))
								state_r <= pei_pkg::SMI_HDR;
						end
					end
					pei_pkg::SMI_HDR:
					begin
						shift_r <= {shift_r[14:0], mdio_s2_r};
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == 5'(pei_pkg::SMI_HDR_LAST))
						begin
							cnt_r <= 5'h00;
							// foreign address or bad opcode: wait for a new preamble
							if (hdr[12] && hdr[9:5] == phy_addr &&
								(hdr[11:10] == pei_pkg::SMI_OP_RD ||
								hdr[11:10] == pei_pkg::SMI_OP_WR))
							begin
								state_r <= pei_pkg::SMI_TA;
								reg_addr <= hdr[4:0];
								is_rd_r <= (hdr[11:10] == pei_pkg::SMI_OP_RD);
								rd_req <= (hdr[11:10] == pei_pkg::SMI_OP_RD);
							end
							else
								state_r <= pei_pkg::SMI_PRE;
						end
					end
					pei_pkg::SMI_TA:
					begin
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == 5'h00)
						begin
							if (is_rd_r)
							begin
								shift_r <= rd_data;
								mdio_oe_n <= 1'b0;
								mdio_out <= 1'b0;
							end
						end
						else
						begin
							state_r <= pei_pkg::SMI_DATA;
							cnt_r <= 5'h00;
							if (is_rd_r)
							begin
								mdio_out <= shift_r[15];
								shift_r <= {shift_r[14:0], 1'b0};
							end
						end
					end
					pei_pkg::SMI_DATA:
					begin
						cnt_r <= cnt_r + 5'h01;
						if (is_rd_r)
						begin
							mdio_out <= shift_r[15];
							shift_r <= {shift_r[14:0], 1'b0};
						end
						else
							shift_r <= {shift_r[14:0], mdio_s2_r};
						if (cnt_r == 5'(pei_pkg::SMI_DATA_LAST))
						begin
							state_r <= pei_pkg::SMI_PRE;
							cnt_r <= 5'h00;
							mdio_oe_n <= 1'b1;
							if (!is_rd_r)
							begin
								wr_data <= {shift_r[14:0], mdio_s2_r};
								wr_req <= 1'b1;
							end
						end
					end
					default:
						state_r <= pei_pkg::SMI_PRE;
				endcase
			end
		end
	end

endmodule

// *** design/pei_irq_logic.sv ***
`timescale 1ns/1ns
// Functional notes
// [R1] irq_out_n goes low whenever an event occurs on a source whose mask bit is set.
// [R2] both schemes assert the output the same way; only deassertion differs.
// [R3] scheme select bit in mode control/status: 0 primary, 1 alternate.
// [R4] primary scheme after every reset; software must select the alternate one.
// [R5] bits 7..1: energy, an done, remote fault, link down, ack, pd fault, page.
// [R6] primary: rising-edge sources clear on their falling edge or a flag register read.
// [R7] primary: link down sets on link falling; clears by status1 or flag read.
// [R8] primary: pd fault and page also clear on reg 6 read, restart, link down.
// [R9] energy flag cleared while energy high: ~1 s after energy falls, assert 256 ms.
// [R10] host should clear the energy mask bit when servicing an energy interrupt.
// [R11] energy mask bit reads 1 after reset, clears soon if no energy is seen.
// [R12] alternate: clearing a mask bit deasserts the output for that source.
// [R13] alternate: write 1 to a flag checks its source; clears only if inactive.
// [R14] alternate: host removes the cause first, then writes 1 to the flag.
// [R15] output is the active-low OR of enabled flags; low while any stays set.
// [R16] registers are reached over the management pins, sampled on rising mdc.
module pei_irq_logic
#(
	parameter int unsigned ED_DELAY_CYC = pei_pkg::ED_DELAY_CYC,
	parameter int unsigned ED_PULSE_CYC = pei_pkg::ED_PULSE_CYC,
	parameter int CNT_W = 28
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	input wire logic [4:0] phy_addr,
	// interrupt pin
	output logic irq_out_n,
	// status from the transceiver core
	input wire logic energy_detect,
	input wire logic an_complete,
	input wire logic remote_fault,
	input wire logic link_up,
	input wire logic lp_ack,
	input wire logic pd_fault,
	input wire logic page_rcvd,
	input wire logic an_restart,
	// other registers of the device
	input wire logic [15:0] ext_rd_data,
	output logic reg_rd_req,
	output logic reg_wr,
	output logic [4:0] reg_addr,
	output logic [15:0] reg_wdata,
	// mode
	output logic alt_irq_scheme_sel
);

	logic [15:0] rd_data_r;
	logic [7:0] src;
	logic [7:0] src_prev_r;
	logic [7:0] flags_r;
	logic [7:0] mask_r;
	logic [7:0] set_ev;
	logic [7:0] clr_prim;
	logic [7:0] clr_alt;
	logic rd_status1;
	logic rd_an_exp;
	logic rd_flags;
	logic wr_flags;
	logic wr_mask;
	logic link_down_ev;
	logic ed_boot_r;
	logic ed_armed_r;
	logic ed_fall;
	logic energy_irq_enable_bit;
	pei_pkg::pei_ed_state_t ed_state_r;
	logic [CNT_W-1:0] ed_cnt_r;

	pei_smi_slave u_smi
	(
		.mclk(mclk),
		.rst(rst),
		.mdc(mdc),
		.mdio_in(mdio_in),
		.mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n),
		.phy_addr(phy_addr),
		.rd_data(rd_data_r),
		.rd_req(reg_rd_req),
		.wr_req(reg_wr),
		.reg_addr(reg_addr),
		.wr_data(reg_wdata)
	);

	////////////////////////////////////////////////////////////////////////
	// source levels, active high; link down is the inverted link state
	assign src = {energy_detect, an_complete, remote_fault, ~link_up,
		lp_ack, pd_fault, page_rcvd, 1'b0}; // [R5]
	assign energy_irq_enable_bit = mask_r[pei_pkg::SRC_ENERGY];

	// read side effects exist only in the primary scheme
	assign rd_status1 = reg_rd_req && reg_addr == pei_pkg::REG_STATUS1 && !alt_irq_scheme_sel;
	assign rd_an_exp = reg_rd_req && reg_addr == pei_pkg::REG_AN_EXP && !alt_irq_scheme_sel;
	assign rd_flags = reg_rd_req && reg_addr == pei_pkg::REG_SRC_FLAGS && !alt_irq_scheme_sel;
	assign wr_flags = reg_wr && reg_addr == pei_pkg::REG_SRC_FLAGS;
	assign wr_mask = reg_wr && reg_addr == pei_pkg::REG_IRQ_MASK;
	assign link_down_ev = set_ev[pei_pkg::SRC_ENERGY-3];

	////////////////////////////////////////////////////////////////////////
	// sync reset samples the levels so no edge is seen at release
	always_ff @(posedge mclk)
	begin
		if (rst)
			src_prev_r <= src;
		else
			src_prev_r <= src;
	end

	assign set_ev[0] = 1'b0;
	assign clr_prim[0] = 1'b0;
	assign clr_alt[0] = 1'b0;

	genvar gi;
	generate
		for (gi = pei_pkg::SRC_LO; gi <= pei_pkg::SRC_HI; gi++)
		begin : g_src
			assign set_ev[gi] = src[gi] & ~src_prev_r[gi]; // [R1] [R2]
			assign clr_prim[gi] = (pei_pkg::FALL_CLR_SET[gi] & ~src[gi] & src_prev_r[gi]) // [R6]
				| rd_flags // [R6]
				| (pei_pkg::RD_STATUS1_CLR_SET[gi] & rd_status1) // [R7]
				| (pei_pkg::RD_AN_EXP_CLR_SET[gi] & rd_an_exp) // [R8]
				| (pei_pkg::RESTART_CLR_SET[gi] & (an_restart | link_down_ev)); // [R8]
			assign clr_alt[gi] = wr_flags & reg_wdata[gi] & ~src[gi]; // [R13]

			// a new event wins over a clear in the same cycle
			always_ff @(posedge mclk)
			begin
				if (rst)
					flags_r[gi] <= 1'b0;
				else if (set_ev[gi])
					flags_r[gi] <= 1'b1;
				else if (alt_irq_scheme_sel ? clr_alt[gi] : clr_prim[gi]) // [R3]
					flags_r[gi] <= 1'b0;
			end
		end
	endgenerate

	assign flags_r[0] = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// scheme select and mask
	always_ff @(posedge mclk)
	begin
		if (rst)
			alt_irq_scheme_sel <= pei_pkg::ALT_SEL_RST; // [R4]
		else if (reg_wr && reg_addr == pei_pkg::REG_MODE_CS)
			alt_irq_scheme_sel <= reg_wdata[pei_pkg::MODE_CS_ALT_BIT]; // [R3]
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mask_r <= pei_pkg::IRQ_MASK_RST[7:0]; // [R11]
			ed_boot_r <= 1'b1;
		end
		else if (wr_mask)
		begin
			mask_r <= {reg_wdata[7:1], 1'b0}; // [R12]
			ed_boot_r <= 1'b0;
		end
		else if (ed_boot_r && !energy_detect)
		begin
			// the start-up mask bit clears the first time energy is low, unless software writes the mask first
			mask_r[pei_pkg::SRC_ENERGY] <= 1'b0; // [R11]
			ed_boot_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// delayed energy pulse; clearing the mask cancels it, which is why the
	// host is expected to drop that bit when it services the interrupt
	assign ed_fall = ~src[pei_pkg::SRC_ENERGY] & src_prev_r[pei_pkg::SRC_ENERGY];

	always_ff @(posedge mclk)
	begin
		if (rst || !energy_irq_enable_bit || alt_irq_scheme_sel)
			ed_armed_r <= 1'b0;
		else if (rd_flags && flags_r[pei_pkg::SRC_ENERGY] && energy_detect)
			ed_armed_r <= 1'b1; // [R9]
		else if (ed_fall)
			ed_armed_r <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || !energy_irq_enable_bit) // [R10]
		begin
			ed_state_r <= pei_pkg::ED_IDLE;
			ed_cnt_r <= '0;
		end
		else
		begin
			case (ed_state_r)
				pei_pkg::ED_IDLE:
				begin
					ed_cnt_r <= '0;
					if (ed_fall && ed_armed_r)
						ed_state_r <= pei_pkg::ED_WAIT; // [R9]
				end
				pei_pkg::ED_WAIT:
				begin
					ed_cnt_r <= ed_cnt_r + 1'b1;
					if (ed_cnt_r == CNT_W'(ED_DELAY_CYC - 1))
					begin
						ed_cnt_r <= '0;
						ed_state_r <= pei_pkg::ED_PULSE; // [R9]
					end
				end
				pei_pkg::ED_PULSE:
				begin
					ed_cnt_r <= ed_cnt_r + 1'b1;
					if (ed_cnt_r == CNT_W'(ED_PULSE_CYC - 1))
						ed_state_r <= pei_pkg::ED_IDLE; // [R9]
				end
				default:
					ed_state_r <= pei_pkg::ED_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one register stage; the pin is glitch free at the cost of one cycle
	always_ff @(posedge mclk)
	begin
		if (rst)
			irq_out_n <= 1'b1;
		else
			irq_out_n <= ~(|(flags_r & mask_r) | (ed_state_r == pei_pkg::ED_PULSE)); // [R15] [R12]
	end

	////////////////////////////////////////////////////////////////////////
	// read data is captured with the request so read-to-clear cannot race it
	always_ff @(posedge mclk)
	begin
		if (rst)
			rd_data_r <= 16'h0000;
		else if (reg_rd_req)
		begin
			if (reg_addr == pei_pkg::REG_SRC_FLAGS)
				rd_data_r <= {8'h00, flags_r}; // [R16]
			else if (reg_addr == pei_pkg::REG_IRQ_MASK)
				rd_data_r <= {8'h00, mask_r};
			else if (reg_addr == pei_pkg::REG_MODE_CS)
			begin
				rd_data_r <= ext_rd_data;
				rd_data_r[pei_pkg::MODE_CS_ENERGY_BIT] <= energy_detect;
				rd_data_r[pei_pkg::MODE_CS_ALT_BIT] <= alt_irq_scheme_sel;
			end
			else
				rd_data_r <= ext_rd_data;
		end
	end

endmodule

// *** sim/pei_host_model.sv ***
`timescale 1ns/1ns
module pei_host_model
#(
	parameter logic [4:0] ADDR = 5'h03,
	parameter int HALF = 5
)
(
	// clock
	input wire logic mclk,
	// management pins
	input wire logic mdio_out,
	input wire logic mdio_oe_n,
	output logic mdc,
	output logic mdio_in
);
	logic drv_en;
	logic drv_v;
	// pulled-up line: nobody driving reads 1
	assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_v : 1'b1);
	initial
	begin
		mdc = 1'b0;
		drv_en = 1'b0;
		drv_v = 1'b1;
	end
	// mdc stands still between frames; data moves only while mdc is low
	task automatic bit_x(input logic en, input logic v, output logic s);
		drv_en <= en;
		drv_v <= v;
		repeat (HALF) @(posedge mclk);
		s = mdio_in;
		mdc <= 1'b1;
		repeat (HALF) @(posedge mclk);
		mdc <= 1'b0;
	endtask
	task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [45:0] hdr;
		logic s;
		logic w;
		hdr = {32'hffff_ffff, 2'b01, op, ADDR, ra};
		w = (op == pei_pkg::SMI_OP_WR);
		for (int i = 45; i >= 0; i--)
			bit_x(1'b1, hdr[i], s);
		bit_x(w, 1'b1, s);
		bit_x(w, 1'b0, s);
		for (int i = 15; i >= 0; i--)
		begin
			bit_x(w, wd[i], s);
			rd[i] = s;
		end
		drv_en <= 1'b0;
	endtask
endmodule

// *** sim/pei_irq_logic_sva.sv ***
`timescale 1ns/1ns
module pei_irq_logic_sva
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pins
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic mdio_oe_n,
	input wire logic irq_out_n,
	// status
	input wire logic energy_detect,
	input wire logic an_complete,
	input wire logic remote_fault,
	input wire logic link_up,
	input wire logic lp_ack,
	input wire logic pd_fault,
	input wire logic page_rcvd,
	// register side
	input wire logic reg_rd_req,
	input wire logic reg_wr,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic alt_irq_scheme_sel
);
	logic [6:1] mask_r;
	logic [6:0] sts;
	logic mode_wr;
	assign sts = {energy_detect, an_complete, remote_fault, link_up, lp_ack, pd_fault, page_rcvd};
	assign mode_wr = reg_wr && reg_addr == pei_pkg::REG_MODE_CS;
	// mask bit 7 is not mirrored: it may also clear by itself
	always_ff @(posedge mclk)
		if (rst)
			mask_r <= '0;
		else if (reg_wr && reg_addr == pei_pkg::REG_IRQ_MASK)
			mask_r <= reg_wdata[6:1];
	////////////////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_flag_read;
		reg_rd_req && reg_addr == pei_pkg::REG_SRC_FLAGS && !alt_irq_scheme_sel;
	endsequence
	sequence s_quiet;
		$stable(sts) [*3];
	endsequence
	AST_RST_IDLE: assert property (disable iff (1'b0) rst |=> irq_out_n && mdio_oe_n
		&& !alt_irq_scheme_sel && !reg_wr && !reg_rd_req) else $error("not idle after reset");
	AST_ALT_WRITE: assert property (mode_wr |-> ##2
		alt_irq_scheme_sel == reg_wdata[pei_pkg::MODE_CS_ALT_BIT]) else $error("scheme not set");
	// the select takes the written value at the edge that sees the write strobe
	AST_ALT_HOLD: assert property ($changed(alt_irq_scheme_sel) |-> $past(mode_wr))
		else $error("scheme changed without write");
	AST_EVENT_IRQ: assert property ((($rose(an_complete) && mask_r[6])
		|| ($fell(link_up) && mask_r[4])) |-> ##[1:4] !irq_out_n) else $error("no interrupt");
	AST_MASK_OFF: assert property (reg_wr && reg_addr == pei_pkg::REG_IRQ_MASK
		&& reg_wdata[7:1] == 7'h00 |-> ##[1:3] irq_out_n) else $error("masked irq held");
	// quiet from the read cycle on: a new event in that cycle would win over the clear
	AST_FLAG_READ: assert property (s_flag_read ##0 s_quiet |=> irq_out_n)
		else $error("flag read did not clear");
	AST_LINK_HOLD: assert property (!alt_irq_scheme_sel && !irq_out_n && mask_r[4]
		&& $rose(link_up) && $stable({sts[6:4], sts[2:0]}) && !reg_rd_req
		&& !$past(reg_rd_req) |=> !irq_out_n) else $error("link rise cleared flag");
	AST_TA_ZERO: assert property ($fell(mdio_oe_n) |-> !mdio_out)
		else $error("turnaround not low");
	AST_OUT_ON_MDC: assert property (($changed(mdio_out) || $changed(mdio_oe_n)) |-> mdc)
		else $error("data line moved off rising mdc");
	AST_REQ_PULSE: assert property ((reg_rd_req || reg_wr) |-> mdc ##1 !(reg_rd_req || reg_wr))
		else $error("access pulse malformed");
endmodule
bind pei_irq_logic pei_irq_logic_sva u_pei_irq_logic_sva
(
	.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
	.irq_out_n(irq_out_n), .energy_detect(energy_detect), .an_complete(an_complete),
	.remote_fault(remote_fault), .link_up(link_up), .lp_ack(lp_ack), .pd_fault(pd_fault),
	.page_rcvd(page_rcvd), .reg_rd_req(reg_rd_req), .reg_wr(reg_wr), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .alt_irq_scheme_sel(alt_irq_scheme_sel)
);

// *** sim/pei_irq_logic_tb.sv ***
`timescale 1ns/1ns
module pei_irq_logic_tb;
	// short counts keep the energy pulse test fast
	localparam int ED_DLY = 20;
	localparam int ED_PLS = 10;
	localparam logic [10:0] EXT_HI = 11'h4b1;
	logic mclk;
	logic rst;
	logic an_restart;
	logic [7:1] ev;
	logic mdc;
	logic mdio_in;
	logic mdio_out;
	logic mdio_oe_n;
	logic irq_out_n;
	logic alt_sel;
	logic [15:0] reg_wdata;
	logic [4:0] reg_addr;
	logic [15:0] ext_rd_data;
	int n_mismatch = 0;
	int compares = 0;
	int t;
	assign ext_rd_data = {EXT_HI, reg_addr};
	pei_irq_logic #(.ED_DELAY_CYC(ED_DLY), .ED_PULSE_CYC(ED_PLS), .CNT_W(28)) u_pei_irq_logic
	(
		.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n), .phy_addr(5'h03), .irq_out_n(irq_out_n),
		.energy_detect(ev[7]), .an_complete(ev[6]), .remote_fault(ev[5]), .link_up(!ev[4]),
		.lp_ack(ev[3]), .pd_fault(ev[2]), .page_rcvd(ev[1]), .an_restart(an_restart),
		.ext_rd_data(ext_rd_data), .reg_rd_req(), .reg_wr(), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .alt_irq_scheme_sel(alt_sel)
	);
	pei_host_model u_pei_host_model
	(
		.mclk(mclk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in)
	);
	////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		$display("watchdog expired");
		end_of_test();
	end
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic irq_chk(input logic e);
		chk("irq_out_n", 16'(irq_out_n), 16'(e));
	endtask
	// status levels move only with no frame in flight
	task automatic set_ev(input logic [7:1] v);
		@(posedge mclk);
		ev <= v;
		repeat (6) @(posedge mclk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] dummy;
		u_pei_host_model.xfer(pei_pkg::SMI_OP_WR, a, d, dummy);
		repeat (4) @(posedge mclk);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input string nm);
		logic [15:0] got;
		u_pei_host_model.xfer(pei_pkg::SMI_OP_RD, a, 16'h0000, got);
		repeat (4) @(posedge mclk);
		chk(nm, got, e);
	endtask
	function automatic logic [15:0] mode_exp(input logic e, input logic a);
		logic [15:0] v;
		v = {EXT_HI, pei_pkg::REG_MODE_CS};
		v[pei_pkg::MODE_CS_ENERGY_BIT] = e;
		v[pei_pkg::MODE_CS_ALT_BIT] = a;
		return v;
	endfunction
	////////////////////////////////
	initial
	begin
		rst = 1'b1;
		an_restart = 1'b0;
		ev = 7'h40;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		rd_chk(pei_pkg::REG_IRQ_MASK, 16'h0080, "mask");
		rd_chk(pei_pkg::REG_MODE_CS, mode_exp(1'b1, 1'b0), "mode");
		set_ev(7'h00);
		rd_chk(pei_pkg::REG_IRQ_MASK, 16'h0000, "mask");
		rd_chk(pei_pkg::REG_SRC_FLAGS, 16'h0000, "flags");
		rd_chk(5'h07, {EXT_HI, 5'h07}, "other");
		$display("test reset done");
		wr(pei_pkg::REG_IRQ_MASK, 16'h00fe);
		for (int i = 1; i <= 7; i++)
		begin
			set_ev(7'h01 << (i - 1));
			irq_chk(1'b0);
			rd_chk(pei_pkg::REG_SRC_FLAGS, 16'h0001 << i, "flags");
			irq_chk(1'b1);
			if (i < 7)
				set_ev(7'h00);
		end
		@(posedge mclk);
		ev <= 7'h00;
		t = 0;
		// counted on the falling edge, away from the edge that moves the pin
		while (irq_out_n !== 1'b0 && t < 200)
		begin
			@(negedge mclk);
			t++;
		end
		chk("delay", 16'(t >= ED_DLY && t <= ED_DLY + 5), 16'h0001);
		t = 0;
		while (irq_out_n === 1'b0 && t < 200)
		begin
			@(negedge mclk);
			t++;
		end
		chk("pulse", 16'(t), 16'(ED_PLS));
		@(posedge mclk);
		wr(pei_pkg::REG_IRQ_MASK, 16'h007e);
		$display("test events done");
		set_ev(7'h20);
		set_ev(7'h00);
		irq_chk(1'b1);
		set_ev(7'h18);
		set_ev(7'h10);
		irq_chk(1'b0);
		set_ev(7'h00);
		irq_chk(1'b0);
		rd_chk(pei_pkg::REG_STATUS1, {EXT_HI, pei_pkg::REG_STATUS1}, "status1");
		irq_chk(1'b1);
		set_ev(7'h02);
		an_restart <= 1'b1;
		@(posedge mclk);
		an_restart <= 1'b0;
		repeat (4) @(posedge mclk);
		irq_chk(1'b1);
		set_ev(7'h03);
		irq_chk(1'b0);
		rd_chk(pei_pkg::REG_AN_EXP, {EXT_HI, pei_pkg::REG_AN_EXP}, "an_exp");
		irq_chk(1'b1);
		set_ev(7'h00);
		set_ev(7'h03);
		set_ev(7'h0b);
		rd_chk(pei_pkg::REG_SRC_FLAGS, 16'h0010, "flags");
		set_ev(7'h00);
		$display("test clears done");
		wr(pei_pkg::REG_MODE_CS, 16'h0040);
		chk("alt_sel", 16'(alt_sel), 16'h0001);
		chk("reg_wdata", reg_wdata, 16'h0040);
		rd_chk(pei_pkg::REG_MODE_CS, mode_exp(1'b0, 1'b1), "mode");
		set_ev(7'h04);
		rd_chk(pei_pkg::REG_SRC_FLAGS, 16'h0008, "flags");
		irq_chk(1'b0);
		wr(pei_pkg::REG_SRC_FLAGS, 16'h0008);
		irq_chk(1'b0);
		set_ev(7'h00);
		wr(pei_pkg::REG_SRC_FLAGS, 16'h0008);
		irq_chk(1'b1);
		set_ev(7'h20);
		irq_chk(1'b0);
		wr(pei_pkg::REG_IRQ_MASK, 16'h0000);
		irq_chk(1'b1);
		rd_chk(pei_pkg::REG_SRC_FLAGS, 16'h0040, "flags");
		$display("test alternate done");
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("alt_sel", 16'(alt_sel), 16'h0000);
		rd_chk(pei_pkg::REG_MODE_CS, mode_exp(1'b0, 1'b0), "mode");
		irq_chk(1'b1);
		$display("test second reset done");
		end_of_test();
	end
endmodule
